//--- verilog/tcp_timer_pkg.sv
package tcp_timer_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] CAP_LOW_IDX = 6'h22;
    localparam logic [5:0] CAP_HIGH_IDX = 6'h23;
    localparam logic [5:0] FLAGS_IDX = 6'h2A;
    localparam logic [5:0] MASK_IDX = 6'h2B;
    localparam logic [5:0] SYNC_CTL_IDX = 6'h2F;
    localparam logic [5:0] EVT_STAT_IDX = 6'h30;

    // Bit positions in flag, mask and event status registers
    localparam int OVF_BIT = 0;
    localparam int MATCH_A_BIT = 1;
    localparam int MATCH_B_BIT = 2;
    localparam int CAPTURE_BIT = 5;
    // Bit positions in the sync/prescale control register
    localparam int PSR_BIT = 0;
    localparam int TSM_BIT = 7;

    // Source order of the internal 4-bit vectors
    localparam int SRC_OVF = 0;
    localparam int SRC_A = 1;
    localparam int SRC_B = 2;
    localparam int SRC_CAP = 3;

    // Reset values and the counter maximum
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] CAP_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // Waveform mode codes
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_CTC_A = 4'h4;
    localparam logic [3:0] MODE_CTC_CAP = 4'hC;
    localparam logic [3:0] MODE_PWM_CAP_A = 4'h8;
    localparam logic [3:0] MODE_PWM_CAP_B = 4'hA;
    localparam logic [3:0] MODE_FAST_CAP = 4'hE;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verilog/tcp_timer_ctl.sv
`timescale 1ns/1ps
// Behaviour
// - Each capture event loads the counter value into the capture register.
// - 16-bit capture access is atomic via one shared high-byte latch.
// - Capture flag, bit 5, sets on every capture event.
// - With capture register as top, capture flag sets when counter reaches top.
// - Capture interrupt needs capture flag, mask bit 5 and global enable; irq uses only event status and mask.
// - Match B interrupt needs match B flag, mask bit 2 and global enable; irq uses only event status and mask.
// - Match A interrupt needs match A flag, mask bit 1 and global enable; irq uses only event status and mask.
// - Overflow interrupt needs overflow flag, mask bit 0 and global enable; irq uses only event status and mask.
// - Match B flag, bit 2, sets one timer tick after counter equals compare B.
// - Match A flag, bit 1, sets one timer tick after counter equals compare A.
// - A forced-compare strobe never sets its channel's match flag.
// - Overflow flag sets on wrap in normal and clear modes; else core event.
// - Executing an interrupt vector clears the matching flag.
// - Writing one clears a flag; writing zero leaves it alone.
// - Prescaler reset bit resets prescaler, cleared at once unless sync hold.
// - In sync hold mode the written prescaler reset stays, counter halted.
// - Writing zero to sync hold clears prescaler reset; counting resumes.
// - A forced-compare strobe gives no interrupt and no clear-on-match.
module tcp_timer_ctl #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Counting core
    input wire logic timerTick,
    input wire logic [15:0] countValue,
    input wire logic [15:0] compareAValue,
    input wire logic [15:0] compareBValue,
    input wire logic [3:0] waveformMode,
    input wire logic overflowModeEvent,
    input wire logic forceMatchAStrobe,
    input wire logic forceMatchBStrobe,
    output logic clearOnMatch,
    output logic [15:0] captureValue,
    output logic prescalerReset,
    output logic counterHalt,
    // Capture front end
    input wire logic captureInputEvent,
    input wire logic comparatorEvent,
    input wire logic comparatorCaptureSel,
    // CPU interrupt side
    input wire logic globalIntEnable,
    input wire logic [3:0] vectorAck,
    output logic [3:0] irqRequest,
    output logic irq
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        // Bus side: held request halves and pending answers
        logic awPend;
        logic [5:0] awIdx;
        logic awBad;
        logic wPend;
        logic [7:0] wByte;
        // Only byte lane 0 reaches the 8-bit registers
        logic wLane0;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [7:0] rByte;
        logic [1:0] rResp;
        // Timer registers and the shared high-byte latch
        logic [15:0] capture;
        logic [7:0] temp;
        logic [3:0] flags;
        logic [3:0] mask;
        logic [3:0] evtStat;
        logic sync_hold_mode;
        logic prescaler_reset_bit;
        // Match seen at one tick; its flag follows at the next
        logic pendA;
        logic pendB;
    } tcp_state_t;

    // Everything idle and cleared
    localparam tcp_state_t STATE_RESET = '{
        awPend: 1'b0, awIdx: 6'h00, awBad: 1'b0, wPend: 1'b0,
        wByte: tcp_timer_pkg::REG_RESET, wLane0: 1'b0, bValid: 1'b0,
        bResp: tcp_timer_pkg::RESP_OKAY, rValid: 1'b0,
        rByte: tcp_timer_pkg::REG_RESET, rResp: tcp_timer_pkg::RESP_OKAY,
        capture: tcp_timer_pkg::CAP_RESET, temp: tcp_timer_pkg::REG_RESET,
        flags: 4'h0, mask: 4'h0, evtStat: 4'h0, sync_hold_mode: 1'b0, prescaler_reset_bit: 1'b0,
        pendA: 1'b0, pendB: 1'b0
    };

    tcp_state_t state_q;
    tcp_state_t state_d;

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Decode slices address bits 7:2
    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("ADDR_W must be at least 8");
    end
    // Every field must land inside the 8-bit register
    if (tcp_timer_pkg::CAPTURE_BIT > 7 || tcp_timer_pkg::TSM_BIT > 7) begin : g_bad_layout
        $error("Register field position outside the byte");
    end

    // ****************************************
    // Decode helpers
    // ****************************************
    // Packs 4 source bits into the 8-bit register layout
    function automatic logic [7:0] toReg(input logic [3:0] v);
        logic [7:0] r;
        r = 8'h00;
        r[tcp_timer_pkg::OVF_BIT] = v[tcp_timer_pkg::SRC_OVF];
        r[tcp_timer_pkg::MATCH_A_BIT] = v[tcp_timer_pkg::SRC_A];
        r[tcp_timer_pkg::MATCH_B_BIT] = v[tcp_timer_pkg::SRC_B];
        r[tcp_timer_pkg::CAPTURE_BIT] = v[tcp_timer_pkg::SRC_CAP];
        return r;
    endfunction

    function automatic logic [3:0] fromReg(input logic [7:0] r);
        logic [3:0] v;
        v[tcp_timer_pkg::SRC_OVF] = r[tcp_timer_pkg::OVF_BIT];
        v[tcp_timer_pkg::SRC_A] = r[tcp_timer_pkg::MATCH_A_BIT];
        v[tcp_timer_pkg::SRC_B] = r[tcp_timer_pkg::MATCH_B_BIT];
        v[tcp_timer_pkg::SRC_CAP] = r[tcp_timer_pkg::CAPTURE_BIT];
        return v;
    endfunction

    // Unmapped offsets answer with an error
    function automatic logic isMapped(input logic [5:0] idx);
        return idx == tcp_timer_pkg::CAP_LOW_IDX || idx == tcp_timer_pkg::CAP_HIGH_IDX
            || idx == tcp_timer_pkg::FLAGS_IDX || idx == tcp_timer_pkg::MASK_IDX
            || idx == tcp_timer_pkg::SYNC_CTL_IDX || idx == tcp_timer_pkg::EVT_STAT_IDX;
    endfunction

    logic captureEvt;
    logic capIsTop;
    logic wrapMode;
    logic matchAEq;
    logic matchBEq;
    logic [3:0] hwSet;
    logic doWrite;
    logic doRead;
    logic [5:0] arIdx;
    logic arBad;

    // ****************************************
    // Event sources
    // ****************************************
    // capture source select
    assign captureEvt = comparatorCaptureSel ? comparatorEvent : captureInputEvent;
    // Modes in which the capture register is the top
    assign capIsTop = waveformMode == tcp_timer_pkg::MODE_CTC_CAP
        || waveformMode == tcp_timer_pkg::MODE_PWM_CAP_A
        || waveformMode == tcp_timer_pkg::MODE_PWM_CAP_B
        || waveformMode == tcp_timer_pkg::MODE_FAST_CAP;
    // Modes whose overflow is a plain wrap at the maximum
    assign wrapMode = waveformMode == tcp_timer_pkg::MODE_NORMAL
        || waveformMode == tcp_timer_pkg::MODE_CTC_A
        || waveformMode == tcp_timer_pkg::MODE_CTC_CAP;
    // Protection bits ignored: every register is unprivileged
    // Strobe B needs no logic: no flag, and B is never top
    // force strobes are not part of the match compare
    assign matchAEq = countValue == compareAValue;
    assign matchBEq = countValue == compareBValue;

    always_comb begin
        hwSet = 4'h0;
        // capture sets flag, capture top reached
        hwSet[tcp_timer_pkg::SRC_CAP] = captureEvt
            || (capIsTop && timerTick && countValue == state_q.capture);
        // flag on the tick after the match
        hwSet[tcp_timer_pkg::SRC_A] = timerTick && state_q.pendA;
        // flag on the tick after the match
        hwSet[tcp_timer_pkg::SRC_B] = timerTick && state_q.pendB;
        // wrap in normal and clear modes, core event otherwise
        hwSet[tcp_timer_pkg::SRC_OVF] = wrapMode
            ? (timerTick && countValue == tcp_timer_pkg::COUNT_MAX)
            : overflowModeEvent;
    end

    // ****************************************
    // Register bus
    // ****************************************
    // Held back while the last response is unanswered
    assign doWrite = state_q.awPend && state_q.wPend && !state_q.bValid;
    assign arIdx = araddr[7:2];
    assign arBad = araddr[1:0] != 2'b00 || (ADDR_W > 8 && (araddr >> 8) != '0)
        || !isMapped(arIdx);
    // One read in flight; a new address waits for the data
    assign doRead = arvalid && !state_q.rValid;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [3:0] w1c;
        logic [7:0] rd;
        logic wr;
        state_d = state_q;
        w1c = 4'h0;
        rd = 8'h00;
        wr = doWrite && !state_q.awBad && state_q.wLane0;

        // Address and data are taken in either order
        if (awvalid && !state_q.awPend) begin
            state_d.awPend = 1'b1;
            state_d.awIdx = awaddr[7:2];
            state_d.awBad = awaddr[1:0] != 2'b00
                || (ADDR_W > 8 && (awaddr >> 8) != '0) || !isMapped(awaddr[7:2]);
        end
        if (wvalid && !state_q.wPend) begin
            state_d.wPend = 1'b1;
            state_d.wByte = wdata[7:0];
            state_d.wLane0 = wstrb[0];
        end
        if (doWrite) begin
            state_d.awPend = 1'b0;
            state_d.wPend = 1'b0;
            state_d.bValid = 1'b1;
            state_d.bResp = state_q.awBad ? tcp_timer_pkg::RESP_SLVERR
                : tcp_timer_pkg::RESP_OKAY;
        end
        if (state_q.bValid && bready) begin
            state_d.bValid = 1'b0;
        end

        // Compare pipeline: remember the match until the next tick
        if (timerTick) begin
            state_d.pendA = matchAEq;
            state_d.pendB = matchBEq;
        end

        // prescaler reset self-clears unless sync hold
        state_d.prescaler_reset_bit = state_q.sync_hold_mode && state_q.prescaler_reset_bit;

        if (wr) begin
            case (state_q.awIdx)
                tcp_timer_pkg::CAP_HIGH_IDX: begin
                    // high byte waits in the shared latch
                    state_d.temp = state_q.wByte;
                end
                tcp_timer_pkg::CAP_LOW_IDX: begin
                    // low write commits both bytes at once
                    state_d.capture = {state_q.temp, state_q.wByte};
                end
                tcp_timer_pkg::FLAGS_IDX: begin
                    w1c = fromReg(state_q.wByte);
                end
                tcp_timer_pkg::MASK_IDX: begin
                    state_d.mask = fromReg(state_q.wByte);
                end
                tcp_timer_pkg::SYNC_CTL_IDX: begin
                    // hold keeps the written reset, zero releases it
                    state_d.sync_hold_mode = state_q.wByte[tcp_timer_pkg::TSM_BIT];
                    state_d.prescaler_reset_bit = state_q.wByte[tcp_timer_pkg::PSR_BIT];
                end
                default: begin
                end
            endcase
        end

        // Read path
        if (doRead) begin
            case (arIdx)
                tcp_timer_pkg::CAP_LOW_IDX: begin
                    // low read latches the high byte for the next read
                    rd = state_q.capture[7:0];
                    state_d.temp = state_q.capture[15:8];
                end
                tcp_timer_pkg::CAP_HIGH_IDX: rd = state_q.temp;
                tcp_timer_pkg::FLAGS_IDX: rd = toReg(state_q.flags);
                tcp_timer_pkg::MASK_IDX: rd = toReg(state_q.mask);
                tcp_timer_pkg::SYNC_CTL_IDX: begin
                    rd = 8'h00;
                    rd[tcp_timer_pkg::TSM_BIT] = state_q.sync_hold_mode;
                    rd[tcp_timer_pkg::PSR_BIT] = state_q.prescaler_reset_bit;
                end
                tcp_timer_pkg::EVT_STAT_IDX: rd = toReg(state_q.evtStat);
                default: rd = 8'h00;
            endcase
            state_d.rValid = 1'b1;
            // Refused reads return zero so no state leaks
            state_d.rByte = arBad ? 8'h00 : rd;
            state_d.rResp = arBad ? tcp_timer_pkg::RESP_SLVERR : tcp_timer_pkg::RESP_OKAY;
        end else if (state_q.rValid && rready) begin
            state_d.rValid = 1'b0;
        end

        // load the counter on capture, beating a same-cycle write
        if (captureEvt) begin
            state_d.capture = countValue;
        end

        // vector clears, write clears; a new event wins over both
        state_d.flags = (state_q.flags & ~w1c & ~vectorAck) | hwSet;
        // Event status clears on read; an event in that cycle is kept
        if (doRead && !arBad && arIdx == tcp_timer_pkg::EVT_STAT_IDX) begin
            state_d.evtStat = hwSet;
        end else begin
            state_d.evtStat = state_q.evtStat | hwSet;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign awready = !state_q.awPend;
    assign wready = !state_q.wPend;
    assign bvalid = state_q.bValid;
    assign bresp = state_q.bResp;
    assign arready = !state_q.rValid;
    assign rvalid = state_q.rValid;
    assign rdata = {24'h000000, state_q.rByte};
    assign rresp = state_q.rResp;

    // ****************************************
    // Interrupts
    // ****************************************
    // One request per source; bit order matches vectorAck
    for (genvar s = 0; s < 4; s++) begin : g_irq_req
        assign irqRequest[s] = state_q.flags[s] && state_q.mask[s] && globalIntEnable;
    end
    // Summary line follows the read-clear status, not the flags
    assign irq = |(state_q.evtStat & state_q.mask);

    // forced compare never clears the counter
    assign clearOnMatch = waveformMode == tcp_timer_pkg::MODE_CTC_A && timerTick
        && state_q.pendA && !forceMatchAStrobe;
    assign captureValue = state_q.capture;
    // prescaler held while the bit is set
    assign prescalerReset = state_q.prescaler_reset_bit;
    assign counterHalt = state_q.prescaler_reset_bit && state_q.sync_hold_mode;

endmodule // tcp_timer_ctl

//--- test/tcp_timer_props.sv
`timescale 1ns/1ps
module tcp_timer_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Core side
    input wire logic timerTick,
    input wire logic [15:0] countValue,
    input wire logic [3:0] waveformMode,
    input wire logic overflowModeEvent,
    input wire logic forceMatchAStrobe,
    input wire logic clearOnMatch,
    input wire logic [15:0] captureValue,
    input wire logic prescalerReset,
    input wire logic counterHalt,
    // Capture and interrupts
    input wire logic captureInputEvent,
    input wire logic comparatorEvent,
    input wire logic comparatorCaptureSel,
    input wire logic globalIntEnable,
    input wire logic [3:0] vectorAck,
    input wire logic [3:0] irqRequest
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_cap_pin;
        captureInputEvent && !comparatorCaptureSel |=> captureValue == $past(countValue);
    endproperty
    a_cap_pin: assert property (p_cap_pin) else $error("pin capture value wrong");
    property p_cap_cmp;
        comparatorEvent && comparatorCaptureSel |=> captureValue == $past(countValue);
    endproperty
    a_cap_cmp: assert property (p_cap_cmp) else $error("comparator capture wrong");
    property p_no_global;
        !globalIntEnable |-> irqRequest == 4'h0;
    endproperty
    a_no_global: assert property (p_no_global) else $error("request without global");
    // Forced strobe must never clear the counter
    property p_clear_cause;
        clearOnMatch |-> timerTick && !forceMatchAStrobe
            && waveformMode == tcp_timer_pkg::MODE_CTC_A;
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("bad clear on match");
    property p_halt;
        counterHalt |-> prescalerReset;
    endproperty
    a_halt: assert property (p_halt) else $error("halt without prescaler reset");
    property p_psr_pulse;
        $rose(prescalerReset) && !counterHalt |=> !prescalerReset;
    endproperty
    a_psr_pulse: assert property (p_psr_pulse) else $error("prescaler reset stuck");
    property p_ack_cap;
        vectorAck[3] && !captureInputEvent && !comparatorEvent && !timerTick
            |=> !irqRequest[3];
    endproperty
    a_ack_cap: assert property (p_ack_cap) else $error("capture ack kept flag");
    property p_ack_ovf;
        vectorAck[0] && !timerTick && !overflowModeEvent |=> !irqRequest[0];
    endproperty
    a_ack_ovf: assert property (p_ack_ovf) else $error("overflow ack kept flag");
    c_clear: cover property (clearOnMatch);
    c_halt: cover property (counterHalt);
    c_ack: cover property (vectorAck[3]);
endmodule // tcp_timer_props

//--- test/tcp_cpu_model.sv
`timescale 1ns/1ps
module tcp_cpu_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Interrupt side
    input wire logic [3:0] irqRequest,
    input wire logic slowAck,
    output logic [3:0] vectorAck
);
    logic [3:0] delay_q;
    // one-cycle acknowledge
    // Lowest vector first; idle cycle after each ack avoids a double ack
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vectorAck <= 4'h0;
            delay_q <= 4'h0;
        end else if (vectorAck != 4'h0 || irqRequest == 4'h0) begin
            vectorAck <= 4'h0;
            delay_q <= 4'h0;
        end else if (!slowAck || delay_q == 4'hF) begin
            vectorAck <= irqRequest & (~irqRequest + 4'h1);
            delay_q <= 4'h0;
        end else begin
            delay_q <= delay_q + 4'h1;
        end
    end
endmodule // tcp_cpu_model

//--- test/timer0_capture_irq_prescaler_ctl_test.sv
`timescale 1ns/1ps
module timer0_capture_irq_prescaler_ctl_test;
    localparam logic [1:0] OK = tcp_timer_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = tcp_timer_pkg::RESP_SLVERR;
    localparam logic [7:0] CL = {tcp_timer_pkg::CAP_LOW_IDX, 2'h0};
    localparam logic [7:0] CH = {tcp_timer_pkg::CAP_HIGH_IDX, 2'h0};
    localparam logic [7:0] FL = {tcp_timer_pkg::FLAGS_IDX, 2'h0};
    localparam logic [7:0] MK = {tcp_timer_pkg::MASK_IDX, 2'h0};
    localparam logic [7:0] SC = {tcp_timer_pkg::SYNC_CTL_IDX, 2'h0};
    localparam logic [7:0] ES = {tcp_timer_pkg::EVT_STAT_IDX, 2'h0};
    logic ref_clk = 1'b0, rst = 1'b1, slowAck = 1'b0, globalIntEnable = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic comparatorCaptureSel = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] countValue = 16'h0, compareAValue = 16'h1, compareBValue = 16'h1;
    logic [15:0] cnt, captureValue;
    logic [3:0] waveformMode = 4'h0, vectorAck, irqRequest;
    logic [5:0] evt = 6'h00;
    logic awready, wready, bvalid, arready, rvalid, clearOnMatch, prescalerReset;
    logic counterHalt, irq, timerTick, captureInputEvent, comparatorEvent;
    logic forceMatchAStrobe, forceMatchBStrobe, overflowModeEvent;
    logic [1:0] bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] rstAddr[4] = '{CL, FL, MK, SC};
    logic [3:0] ovfMode[4] = '{4'h0, 4'h4, 4'hA, 4'hE};
    logic [5:0] ovfEvt[4] = '{6'h01, 6'h01, 6'h20, 6'h20};
    int errors = 0, cmpCount = 0, cyc = 0;
    assign {overflowModeEvent, forceMatchBStrobe, forceMatchAStrobe, comparatorEvent,
        captureInputEvent, timerTick} = evt;
    always #4 ref_clk = ~ref_clk;
    tcp_timer_ctl u_dut (.ref_clk, .rst, .awvalid, .awready, .awaddr, .awprot(3'h0),
        .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready(1'b1), .bresp,
        .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .timerTick, .countValue, .compareAValue, .compareBValue, .waveformMode,
        .overflowModeEvent, .forceMatchAStrobe, .forceMatchBStrobe, .clearOnMatch,
        .captureValue, .prescalerReset, .counterHalt, .captureInputEvent,
        .comparatorEvent, .comparatorCaptureSel, .globalIntEnable, .vectorAck,
        .irqRequest, .irq);
    tcp_cpu_model u_cpu (.ref_clk, .rst, .irqRequest, .slowAck, .vectorAck);
    // ********
    // Bus tasks
    // ********
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic pulse(input logic [5:0] v);
        evt <= v;
        @(posedge ref_clk);
        evt <= 6'h00;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        fork
            begin
                do @(posedge ref_clk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge ref_clk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        do @(posedge ref_clk); while (!bvalid);
    endtask
    // Random stall before rready exercises the held read answer
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        rq.push_back({r, 24'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        repeat ($urandom % 3) @(posedge ref_clk);
        rready <= 1'b1;
        do @(posedge ref_clk); while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("Mismatches %0d, comparisons %0d", errors, cmpCount);
        if (errors == 0 && cmpCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Ceiling far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        if (rvalid && rready)
            check({rresp, rdata}, rq.pop_front());
        if (bvalid)
            check(34'(bresp), 34'(bq.pop_front()));
        cyc++;
        if (cyc == 30000) begin
            errors++;
            print_verdict();
        end
    end
    // ********
    // Scenarios
    // ********
    initial begin
        cnt = 16'($urandom(97));
        // Never zero, never one, never all ones
        cnt = (16'($urandom) | 16'h0200) & 16'hFEFE;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (rstAddr[i]) rd(rstAddr[i], tcp_timer_pkg::REG_RESET, OK);
        rd(8'h00, 8'h00, ERR);
        wr(8'h03, 8'hFF, ERR);
        countValue <= cnt;
        pulse(6'h02);
        rd(CL, cnt[7:0], OK);
        rd(CH, cnt[15:8], OK);
        wr(FL, 8'h00, OK);
        rd(FL, 8'h20, OK);
        wr(FL, 8'h20, OK);
        rd(FL, 8'h00, OK);
        comparatorCaptureSel <= 1'b1;
        countValue <= ~cnt;
        pulse(6'h04);
        rd(CL, ~cnt[7:0], OK);
        countValue <= cnt;
        pulse(6'h04);
        rd(CH, ~cnt[15:8], OK);
        comparatorCaptureSel <= 1'b0;
        wr(FL, 8'h27, OK);
        waveformMode <= tcp_timer_pkg::MODE_CTC_CAP;
        pulse(6'h01);
        rd(FL, 8'h20, OK);
        wr(FL, 8'h27, OK);
        rd(ES, 8'h20, OK);
        waveformMode <= tcp_timer_pkg::MODE_PWM_CAP_A;
        wr(MK, 8'h21, OK);
        rd(MK, 8'h21, OK);
        globalIntEnable <= 1'b1;
        slowAck <= 1'b1;
        pulse(6'h22);
        check(34'(irq), 34'h1);
        repeat (60) @(posedge ref_clk);
        rd(FL, 8'h00, OK);
        rd(ES, 8'h21, OK);
        @(posedge ref_clk);
        check(34'(irq), 34'h0);
        wr(MK, 8'h00, OK);
        pulse(6'h02);
        check(34'(irq), 34'h0);
        rd(FL, 8'h20, OK);
        globalIntEnable <= 1'b0;
        wr(FL, 8'h27, OK);
        waveformMode <= tcp_timer_pkg::MODE_CTC_A;
        compareAValue <= cnt;
        compareBValue <= cnt;
        pulse(6'h18);
        rd(FL, 8'h00, OK);
        pulse(6'h01);
        rd(FL, 8'h00, OK);
        pulse(6'h09);
        rd(FL, 8'h06, OK);
        evt <= 6'h01;
        @(posedge ref_clk);
        check(34'(clearOnMatch), 34'h1);
        evt <= 6'h09;
        @(posedge ref_clk);
        check(34'(clearOnMatch), 34'h0);
        evt <= 6'h00;
        @(posedge ref_clk);
        countValue <= 16'hFFFF;
        pulse(6'h01);
        foreach (ovfMode[i]) begin
            wr(FL, 8'h27, OK);
            waveformMode <= ovfMode[i];
            pulse(ovfEvt[i]);
            rd(FL, 8'h01, OK);
        end
        wr(SC, 8'h01, OK);
        rd(SC, 8'h00, OK);
        wr(SC, 8'h81, OK);
        rd(SC, 8'h81, OK);
        check(34'(counterHalt), 34'h1);
        wr(SC, 8'h00, OK);
        rd(SC, 8'h00, OK);
        check(34'(counterHalt), 34'h0);
        print_verdict();
    end
endmodule // timer0_capture_irq_prescaler_ctl_test
bind tcp_timer_ctl tcp_timer_props u_props (.ref_clk, .rst, .timerTick, .countValue,
    .waveformMode, .overflowModeEvent, .forceMatchAStrobe, .clearOnMatch, .captureValue,
    .prescalerReset, .counterHalt, .captureInputEvent, .comparatorEvent,
    .comparatorCaptureSel, .globalIntEnable, .vectorAck, .irqRequest);
